// ===== hw/cosc_bank.sv
// two channel output select configuration registers and their decode
// assumes the device register port gives a one-cycle write strobe and mode flags
`include "cosc_defs.svh"
module cosc_bank (
    input wire logic clk,
    input wire logic srst,
    input wire logic modeDsi3,
    input wire logic modeSpi,
    input wire logic modeI2c,
    input wire logic modePsi5Prog,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regHit,
    input wire logic [1:0] ch0OffsetFilterSel,
    input wire logic [1:0] ch1OffsetFilterSel,
    input wire logic ch0DspInitDone,
    input wire logic ch1DspInitDone,
    input wire logic [15:0] ch0Slot0Raw,
    input wire logic [15:0] ch0Slot1Raw,
    input wire logic [15:0] ch1Slot0Raw,
    input wire logic [15:0] ch1Slot1Raw,
    output logic [15:0] ch0Slot0Result,
    output logic [15:0] ch0Slot1Result,
    output logic [15:0] ch1Slot0Result,
    output logic [15:0] ch1Slot1Result,
    output logic ch0ResultValid,
    output logic ch1ResultValid,
    output cosc_pkg::cosc_chain_t ch0Chain,
    output cosc_pkg::cosc_chain_t ch1Chain,
    output logic [15:0] cfgCheckWord
);
    cosc_pkg::cosc_cfg_t cfg_q [2];
    logic [1:0] dspReset_q;
    logic [1:0] pending_q;
    logic accessOk;
    logic [1:0] wrHit;
    logic [1:0] initDone;
    logic [1:0] [15:0] s0Raw;
    logic [1:0] [15:0] s1Raw;
    logic [1:0] [15:0] s0Fmt;
    logic [1:0] [15:0] s1Fmt;
    logic [1:0] [1:0] ocSel;
    cosc_pkg::cosc_chain_t chain [2];

    // register port open in every host-facing mode
    assign accessOk = modeDsi3 | modeSpi | modeI2c | modePsi5Prog; // RULE_01
    assign wrHit[0] = accessOk && regWrite && (regAddr == `COSC_ADDR_CH0);
    assign wrHit[1] = accessOk && regWrite && (regAddr == `COSC_ADDR_CH1);
    assign initDone = {ch1DspInitDone, ch0DspInitDone};
    assign s0Raw = {ch1Slot0Raw, ch0Slot0Raw};
    assign s1Raw = {ch1Slot1Raw, ch0Slot1Raw};
    assign ocSel = {ch1OffsetFilterSel, ch0OffsetFilterSel};

    // read mux
    always_comb begin
        regHit = 1'b0;
        regRdata = 8'h00;
        if (accessOk && regAddr == `COSC_ADDR_CH0) begin
            regHit = 1'b1;
            regRdata = cfg_q[0]; // RULE_01
        end else if (accessOk && regAddr == `COSC_ADDR_CH1) begin
            regHit = 1'b1;
            regRdata = cfg_q[1];
        end
    end

    // contents exposed to the array error check
    assign cfgCheckWord = {cfg_q[1], cfg_q[0]}; // RULE_02

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            // configuration storage, one copy per channel
            always_ff @(posedge clk) begin
                if (srst) begin
                    cfg_q[ch] <= `COSC_RESET_VAL;
                end else if (wrHit[ch]) begin
                    cfg_q[ch] <= regWdata; // RULE_03 RULE_11
                end
            end

            // a changed byte pulses the channel DSP reset
            always_ff @(posedge clk) begin
                if (srst) begin
                    dspReset_q[ch] <= 1'b0;
                end else begin
                    dspReset_q[ch] <= wrHit[ch] && (regWdata != cfg_q[ch]); // RULE_08 RULE_11
                end
            end

            // results held invalid until initialisation completes
            always_ff @(posedge clk) begin
                if (srst) begin
                    pending_q[ch] <= 1'b0;
                end else if (dspReset_q[ch]) begin
                    pending_q[ch] <= 1'b1; // RULE_09
                end else if (initDone[ch]) begin
                    pending_q[ch] <= 1'b0;
                end
            end

            cosc_decode u_decode (
                .cfg(cfg_q[ch]),
                .offsetFilterSel(ocSel[ch]),
                .slot0(chain[ch].slot0),
                .slot1(chain[ch].slot1),
                .avgBypass(chain[ch].avgBypass),
                .avgPeriodCycles(chain[ch].avgPeriodCycles)
            );
            assign chain[ch].unsignedOut = cfg_q[ch].unsignedOut;
            assign chain[ch].offsetFilterSel = ocSel[ch];
            assign chain[ch].dspReset = dspReset_q[ch];

            cosc_sign_fmt u_fmt0 (
                .unsignedOut(cfg_q[ch].unsignedOut),
                .isTemp(chain[ch].slot0.src == cosc_pkg::COSC_SRC_TEMP),
                .rawIn(s0Raw[ch]),
                .fmtOut(s0Fmt[ch])
            );
            cosc_sign_fmt u_fmt1 (
                .unsignedOut(cfg_q[ch].unsignedOut),
                .isTemp(chain[ch].slot1.src == cosc_pkg::COSC_SRC_TEMP),
                .rawIn(s1Raw[ch]),
                .fmtOut(s1Fmt[ch])
            );
        end
    endgenerate

    // registered formatted results
    always_ff @(posedge clk) begin
        if (srst) begin
            ch0Slot0Result <= 16'h0000;
            ch0Slot1Result <= 16'h0000;
            ch1Slot0Result <= 16'h0000;
            ch1Slot1Result <= 16'h0000;
        end else begin
            ch0Slot0Result <= s0Fmt[0]; // RULE_04
            ch0Slot1Result <= s1Fmt[0];
            ch1Slot0Result <= s0Fmt[1];
            ch1Slot1Result <= s1Fmt[1];
        end
    end

    assign ch0ResultValid = !pending_q[0] && !dspReset_q[0]; // RULE_09
    assign ch1ResultValid = !pending_q[1] && !dspReset_q[1];
    assign ch0Chain = chain[0];
    assign ch1Chain = chain[1];
endmodule

// ===== hw/cosc_decode.sv
// decodes one channel configuration byte into chain controls
// assumes the offset filter select comes from a neighbouring register
`include "cosc_defs.svh"
module cosc_decode (
    input wire cosc_pkg::cosc_cfg_t cfg,
    input wire logic [1:0] offsetFilterSel,
    output cosc_pkg::cosc_slot_t slot0,
    output cosc_pkg::cosc_slot_t slot1,
    output logic avgBypass,
    output logic [8:0] avgPeriodCycles
);
    localparam int P1 = `COSC_AVG_PERIOD1_US * `COSC_CLK_MHZ;
    localparam int P2 = `COSC_AVG_PERIOD2_US * `COSC_CLK_MHZ;
    localparam int P3 = `COSC_AVG_PERIOD3_US * `COSC_CLK_MHZ;
    logic filterOn;

    // averaging and interpolation from the period select
    always_comb begin
        filterOn = (offsetFilterSel != 2'h3);
        avgBypass = (cfg.avgSel == 2'h0); // RULE_07
        unique case (cfg.avgSel)
            2'h0: avgPeriodCycles = 9'h000;
            2'h1: avgPeriodCycles = 9'(P1 / 4); // RULE_07
            2'h2: avgPeriodCycles = 9'(P2 / 4);
            2'h3: avgPeriodCycles = 9'(P3 / 4); // longest count needs the ninth bit
        endcase
    end

    // slot-0 source
    always_comb begin
        slot0.interp = avgBypass; // RULE_05
        slot0.movingAvg = !avgBypass;
        unique case (cfg.slot0Type)
            2'h0: begin
                slot0.src = cosc_pkg::COSC_SRC_FILTERED;
                slot0.offsetCancel = filterOn; // RULE_05
            end
            2'h1: begin
                slot0.src = cosc_pkg::COSC_SRC_RAW;
                slot0.offsetCancel = 1'b0;
            end
            default: begin
                slot0.src = cosc_pkg::COSC_SRC_TEMP; // RULE_05
                slot0.offsetCancel = 1'b0;
            end
        endcase
    end

    // slot-1 source, never interpolated
    always_comb begin
        slot1.interp = 1'b0; // RULE_06
        slot1.offsetCancel = 1'b0;
        slot1.movingAvg = 1'b0;
        if (cfg.slot1Type[1]) begin
            slot1.src = cosc_pkg::COSC_SRC_TEMP; // RULE_06
        end else if (cfg.slot1Type[0]) begin
            slot1.src = cosc_pkg::COSC_SRC_RAW;
            slot1.movingAvg = !avgBypass; // RULE_06
        end else begin
            slot1.src = cosc_pkg::COSC_SRC_FILTERED;
            slot1.offsetCancel = filterOn;
            slot1.movingAvg = !cfg.slot1Type[2] && !avgBypass; // RULE_06
        end
    end
endmodule

// ===== hw/cosc_defs.svh
// constants for the channel output select configuration bank
// assumes a byte-wide register port shared with the device register array
// Overview of operation
// [RULE_01] both channel registers read and write in DSI3, SPI, I2C and PSI5 programming modes
// [RULE_02] both channel registers feed the register array error check
// [RULE_03] bit 7 signedness, 6:5 slot-0 type, 4:2 slot-1 type, 1:0 averaging
// [RULE_04] signedness 0 gives signed sensor data, 1 unsigned; temperature keeps format
// [RULE_05] slot-0 type 00 filtered, 01 no offset cancel, 1x temperature
// [RULE_06] slot-1 types pick offset cancel and averaging; never interpolation
// [RULE_07] average select 00 bypass with interpolation; others 8-sample 32/64/128 us; code gives avgPeriodCycles of 80/160/320 cycles (8/16/32 us)
// [RULE_08] any change to a channel register resets that channel's DSP path
// [RULE_09] sensor results are not valid until DSP initialisation finishes
// [RULE_10] host should avoid sensor reads while DSP initialises
// [RULE_11] each channel's fields steer only its own chain
`ifndef COSC_DEFS_SVH
`define COSC_DEFS_SVH
`define COSC_ADDR_CH0 8'h42
`define COSC_ADDR_CH1 8'h4A
`define COSC_RESET_VAL 8'h00
`define COSC_BIT_SIGN 7
`define COSC_SLOT0_HI 6
`define COSC_SLOT0_LO 5
`define COSC_SLOT1_HI 4
`define COSC_SLOT1_LO 2
`define COSC_AVG_HI 1
`define COSC_AVG_LO 0
`define COSC_AVG_PERIOD1_US 32
`define COSC_AVG_PERIOD2_US 64
`define COSC_AVG_PERIOD3_US 128
`define COSC_CLK_MHZ 10
`define COSC_AVG_DEPTH 8
`endif

// ===== hw/cosc_pkg.sv
// types for the channel output select configuration bank
// assumes the constants header sits beside it
package cosc_pkg;
    typedef enum logic [1:0] {
        COSC_SRC_FILTERED = 2'b00,
        COSC_SRC_RAW = 2'b01,
        COSC_SRC_TEMP = 2'b10,
        COSC_SRC_NONE = 2'b11
    } cosc_src_t;

    typedef struct packed {
        logic unsignedOut;
        logic [1:0] slot0Type;
        logic [2:0] slot1Type;
        logic [1:0] avgSel;
    } cosc_cfg_t;

    // decoded controls for one output slot
    typedef struct packed {
        cosc_src_t src;
        logic offsetCancel;
        logic movingAvg;
        logic interp;
    } cosc_slot_t;

    // decoded controls for one channel chain
    typedef struct packed {
        logic unsignedOut;
        cosc_slot_t slot0;
        cosc_slot_t slot1;
        logic avgBypass;
        logic [8:0] avgPeriodCycles;
        logic [1:0] offsetFilterSel;
        logic dspReset;
    } cosc_chain_t;
endpackage

// ===== hw/cosc_sign_fmt.sv
// formats one slot result as signed or unsigned
// assumes two's complement input from the chain
module cosc_sign_fmt (
    input wire logic unsignedOut,
    input wire logic isTemp,
    input wire logic [15:0] rawIn,
    output logic [15:0] fmtOut
);
    // offset binary flips the msb; temperature passes untouched
    always_comb begin
        fmtOut = rawIn;
        if (unsignedOut && !isTemp) begin
            fmtOut = {~rawIn[15], rawIn[14:0]}; // RULE_04
        end
    end
endmodule

// ===== tb/channel_output_select_config_tb.sv
// bench for the channel output select bank with two dsp models
// assumes package, bank, checker and model compiled first
module channel_output_select_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] mode = 4'h1;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [1:0] ofs = 2'h0;
    logic [15:0] raw = 16'h1234;
    logic [7:0] rdat;
    logic hit, v0, v1, d0, d1;
    logic [15:0] res0, cw;
    logic [15:0] res01, res10, res11;
    // slot-1 codes with offset cancel and with averaging, one bit per code
    logic [7:0] ocExp = 8'h11;
    logic [7:0] maExp = 8'h23;
    cosc_pkg::cosc_chain_t c0, c1;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    cosc_bank uut (.clk(clk), .srst(srst), .modeDsi3(mode[0]), .modeSpi(mode[1]), .modeI2c(mode[2]),
        .modePsi5Prog(mode[3]), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRdata(rdat),
        .regHit(hit), .ch0OffsetFilterSel(ofs), .ch1OffsetFilterSel(ofs), .ch0DspInitDone(d0),
        .ch1DspInitDone(d1), .ch0Slot0Raw(raw), .ch0Slot1Raw(raw), .ch1Slot0Raw(raw), .ch1Slot1Raw(raw),
        .ch0Slot0Result(res0), .ch0Slot1Result(res01), .ch1Slot0Result(res10), .ch1Slot1Result(res11),
        .ch0ResultValid(v0), .ch1ResultValid(v1), .ch0Chain(c0), .ch1Chain(c1), .cfgCheckWord(cw));
    cosc_dsp_model dsp0 (.clk(clk), .dspReset(c0.dspReset), .initDone(d0));
    cosc_dsp_model dsp1 (.clk(clk), .dspReset(c1.dspReset), .initDone(d1));
    // clock and hang limit
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk);
        regAddr = a;
        #1;
        check("read", {8'h00, rdat}, {8'h00, exp});
    endtask
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // test sequence
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        rd(8'h42, 8'h00);
        rd(8'h43, 8'h00);
        check("hit", {15'h0, hit}, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            mode = 4'h1 << i;
            wr(8'h4A, 8'(8'h10 + i));
            rd(8'h4A, 8'(8'h10 + i));
            check("hit", {15'h0, hit}, 16'h0001);
        end
        mode = 4'h0;
        wr(8'h4A, 8'h77);
        mode = 4'h1;
        rd(8'h4A, 8'h13);
        check("iso", {15'h0, v0}, 16'h0001);
        $display("mode test done");
        wr(8'h42, 8'h80);
        check("dsp", {14'h0, c0.dspReset, v0}, 16'h0002);
        for (int k = 0; k < 50 && v0 !== 1'b1; k++) begin
            @(negedge clk);
        end
        check("valid", {15'h0, v0}, 16'h0001);
        check("valid1", {15'h0, v1}, 16'h0001);
        wr(8'h42, 8'h80);
        check("same", {15'h0, c0.dspReset}, 16'h0000);
        $display("dsp test done");
        check("unsigned", res0, 16'h9234);
        check("unsigned1", res01, 16'h9234);
        check("ch1slot0", res10, 16'h1234);
        check("ch1slot1", res11, 16'h1234);
        wr(8'h42, 8'hC0);
        // results are registered: let the new format reach them
        @(negedge clk);
        check("temp", res0, 16'h1234);
        check("tempslot1", res01, 16'h9234);
        wr(8'h42, 8'h00);
        raw = 16'hF00D;
        @(negedge clk);
        check("signed", res0, 16'hF00D);
        $display("format test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h42, 8'(i << 5));
            check("slot0", 16'(c0.slot0.src), i[1] ? 16'h0002 : 16'(i));
            wr(8'h42, 8'(i));
            check("avg", {14'h0, c0.avgBypass, c0.slot0.interp}, (i == 0) ? 16'h0003 : 16'h0000);
            check("period", 16'(c0.avgPeriodCycles),
                (i == 0) ? 16'h0000 : (i == 1) ? 16'h0050 : (i == 2) ? 16'h00A0 : 16'h0140);
        end
        for (int i = 0; i < 8; i++) begin
            wr(8'h42, 8'((i << 2) | 1));
            check("slot1", {13'h0, c0.slot1.src, c0.slot1.interp}, {13'h0, i[1] ? 2'h2 : {1'b0, i[0]}, 1'b0});
            check("slot1ctl", {14'h0, c0.slot1.offsetCancel, c0.slot1.movingAvg},
                {14'h0, ocExp[i], maExp[i]});
        end
        check("array", cw, 16'h131D);
        // offset filter bypassed turns offset cancellation off in both slots
        ofs = 2'h3;
        wr(8'h42, 8'h00);
        check("ocbypass", {14'h0, c0.slot0.offsetCancel, c0.slot1.offsetCancel}, 16'h0000);
        ofs = 2'h0;
        @(negedge clk);
        check("ocon", {14'h0, c0.slot0.offsetCancel, c0.slot1.offsetCancel}, 16'h0003);
        $display("decode test done");
        final_report();
    end
endmodule

// ===== tb/cosc_bank_chk.sv
// assertions on the channel output select bank ports
// assumes it is bound into every cosc_bank
module cosc_bank_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic modeDsi3,
    input wire logic modeSpi,
    input wire logic modeI2c,
    input wire logic modePsi5Prog,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic ch0DspInitDone,
    input wire logic [15:0] ch0Slot0Raw,
    input wire logic [15:0] ch0Slot0Result,
    input wire logic ch0ResultValid,
    input wire cosc_pkg::cosc_chain_t ch0Chain,
    input wire cosc_pkg::cosc_chain_t ch1Chain,
    input wire logic [15:0] cfgCheckWord
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    // writes the bank must take, per channel
    wire logic portOpen = modeDsi3 | modeSpi | modeI2c | modePsi5Prog;
    wire logic wr0 = regWrite && portOpen && regAddr == 8'h42;
    wire logic wr1 = regWrite && portOpen && regAddr == 8'h4A;
    sequence s_chg0;
        wr0 && regWdata != cfgCheckWord[7:0];
    endsequence
    property p_take0;
        wr0 |=> cfgCheckWord[7:0] == $past(regWdata);
    endproperty
    a_take0: assert property (p_take0) else $error("ch0 write lost");
    property p_take1;
        wr1 |=> cfgCheckWord[15:8] == $past(regWdata) && $stable(cfgCheckWord[7:0]);
    endproperty
    a_take1: assert property (p_take1) else $error("ch1 write lost");
    property p_shut;
        regWrite && !portOpen |=> $stable(cfgCheckWord);
    endproperty
    a_shut: assert property (p_shut) else $error("write with port shut");
    property p_rst;
        s_chg0 |=> ch0Chain.dspReset && !ch0ResultValid;
    endproperty
    a_rst: assert property (p_rst) else $error("no path reset");
    property p_same;
        wr0 && regWdata == cfgCheckWord[7:0] |=> !ch0Chain.dspReset;
    endproperty
    a_same: assert property (p_same) else $error("reset on equal write");
    property p_iso;
        wr1 |=> !ch0Chain.dspReset;
    endproperty
    a_iso: assert property (p_iso) else $error("ch1 write hit ch0");
    property p_hold;
        !ch0ResultValid && !ch0DspInitDone |=> !ch0ResultValid;
    endproperty
    a_hold: assert property (p_hold) else $error("valid before init");
    property p_sign;
        1'b1 |=> ch0Slot0Result == ($past(ch0Slot0Raw) ^ {$past(cfgCheckWord[7]) & ~$past(cfgCheckWord[6]), 15'h0000});
    endproperty
    a_sign: assert property (p_sign) else $error("slot0 format");
    property p_avg;
        ch0Chain.avgBypass == (cfgCheckWord[1:0] == 2'h0) && !ch0Chain.slot1.interp;
    endproperty
    a_avg: assert property (p_avg) else $error("average decode");
endmodule
bind cosc_bank cosc_bank_chk chk (.*);

// ===== tb/cosc_dsp_model.sv
// dsp model: ends initialisation a fixed time after a path reset
// assumes the bank's one-cycle reset pulse
module cosc_dsp_model #(parameter int INIT_CYCLES = 6) (
    input wire logic clk,
    input wire logic dspReset,
    output logic initDone
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt = 8'h00;
    // count down from the pulse, flag done as it expires
    always @(posedge clk) begin
        if (dspReset) begin
            cnt <= 8'(INIT_CYCLES);
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
        initDone <= (cnt == 8'h01);
    end
endmodule
